// >>> design/dfre_defines.vh
`ifndef DFRE_DEFINES_VH
`define DFRE_DEFINES_VH
// ****************************************
// Instruction word layout
// ****************************************
`define DFRE_OPC_HI 15
`define DFRE_OPC_LO 10
`define DFRE_OPC_VAL 6'h01
`define DFRE_DEST_BIT 9
`define DFRE_ACC_BIT 8
`define DFRE_ADDR_HI 7
`define DFRE_ADDR_LO 0
// ****************************************
// Addressing limits
// ****************************************
`define DFRE_IDX_MAX 8'h5f
`define DFRE_ACC_SPLIT 8'h60
`define DFRE_ACC_HI_BANK 4'hf
// ****************************************
// Phase codes and reset values
// ****************************************
`define DFRE_PH_Q1 2'h0
`define DFRE_PH_Q2 2'h1
`define DFRE_PH_Q3 2'h2
`define DFRE_PH_Q4 2'h3
`define DFRE_RST_BYTE 8'h00
`define DFRE_RST_ADDR 12'h000
`define DFRE_RST_FLAGS 5'h00
`endif

// >>> design/dfre_exec.v
`include "dfre_defines.vh"

module dfre_exec #(
	parameter DATA_W = 8,
	parameter ADDR_W = 12
) (
	input wire i_core_clk,
	input wire i_arst_n,
	input wire i_start,
	input wire [15:0] i_instr,
	input wire i_ext_set_en,
	input wire [3:0] i_bank_select_value,
	input wire [ADDR_W-1:0] i_index_base,
	input wire [DATA_W-1:0] i_mem_rdata,
	output wire o_busy,
	output wire o_illegal,
	output reg o_mem_rd,
	output reg o_mem_wr,
	output reg [ADDR_W-1:0] o_mem_addr,
	output reg [DATA_W-1:0] o_mem_wdata,
	output reg o_acc_wr,
	output reg [DATA_W-1:0] o_acc_wdata,
	output reg o_flag_wr,
	output reg o_carry_flag,
	output reg o_digit_carry_flag,
	output reg o_negative_flag,
	output reg o_overflow_flag,
	output reg o_zero_flag,
	output reg o_done
);

	// ****************************************
	// Effective address
	// ****************************************
	function [ADDR_W-1:0] eff_addr;
		input [15:0] ins;
		input ext;
		input [3:0] bsel;
		input [ADDR_W-1:0] ibase;
		reg [7:0] f;
		begin
			f = ins[`DFRE_ADDR_HI:`DFRE_ADDR_LO];
			if (ext && !ins[`DFRE_ACC_BIT] && f <= `DFRE_IDX_MAX) begin
				eff_addr = ibase + {{(ADDR_W-8){1'b0}}, f};
			end else if (!ins[`DFRE_ACC_BIT]) begin
				eff_addr = (f < `DFRE_ACC_SPLIT) ? {4'h0, f} : {`DFRE_ACC_HI_BANK, f};
			end else begin
				eff_addr = {bsel, f};
			end
		end
	endfunction

	// Opcode match is reused for accept and the illegal flag
	function is_decr;
		input [15:0] ins;
		begin
			is_decr = (ins[`DFRE_OPC_HI:`DFRE_OPC_LO] == `DFRE_OPC_VAL);
		end
	endfunction

	// ****************************************
	// State and datapath registers
	// ****************************************
	reg [1:0] phase_q;
	reg active_q;
	reg dest_q;
	reg [DATA_W-1:0] opnd_q;
	reg [DATA_W-1:0] res_q;
	reg [4:0] flags_q;
	reg [DATA_W-1:0] res_d;
	reg [4:0] flags_d;
	wire [DATA_W:0] diff;
	wire [4:0] nib_diff;
	wire take;
	wire write_ph;

	// ****************************************
	// Handshake outputs
	// ****************************************
	assign o_busy = active_q;
	assign o_illegal = i_start && !active_q && !is_decr(i_instr);

	// Words arriving while busy are dropped, the core must wait
	assign take = (phase_q == `DFRE_PH_Q1) && i_start && is_decr(i_instr);
	assign write_ph = (phase_q == `DFRE_PH_Q4);

	assign diff = {1'b0, opnd_q} + {1'b0, {DATA_W{1'b1}}};
	assign nib_diff = {1'b0, opnd_q[3:0]} + 5'h0f;

	// ****************************************
	// Result and status flags
	// ****************************************
	always @* begin
		res_d = diff[DATA_W-1:0];
		flags_d[0] = diff[DATA_W];
		flags_d[1] = nib_diff[4];
		flags_d[2] = diff[DATA_W-1];
		// overflow only leaving most negative byte
		flags_d[3] = (opnd_q == {1'b1, {(DATA_W-1){1'b0}}});
		flags_d[4] = (res_d == {DATA_W{1'b0}});
	end

	// ****************************************
	// Four phase sequencer
	// ****************************************
	// Idle parks in phase one so a new word is decoded on any rising edge
	always @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			phase_q <= `DFRE_PH_Q1;
			active_q <= 1'b0;
			dest_q <= 1'b0;
		end else begin
			case (phase_q)
				`DFRE_PH_Q1: begin
					if (take) begin
						active_q <= 1'b1;
						dest_q <= i_instr[`DFRE_DEST_BIT];
						phase_q <= `DFRE_PH_Q2;
					end
				end
				`DFRE_PH_Q2: begin
					phase_q <= `DFRE_PH_Q3;
				end
				`DFRE_PH_Q3: begin
					phase_q <= `DFRE_PH_Q4;
				end
				`DFRE_PH_Q4: begin
					active_q <= 1'b0;
					phase_q <= `DFRE_PH_Q1;
				end
				default: begin
					phase_q <= `DFRE_PH_Q1;
					active_q <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// Operand read stage
	// ****************************************
	always @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mem_rd <= 1'b0;
			o_mem_addr <= `DFRE_RST_ADDR;
			opnd_q <= `DFRE_RST_BYTE;
		end else begin
			o_mem_rd <= take;
			if (take) begin
				o_mem_addr <= eff_addr(i_instr, i_ext_set_en, i_bank_select_value, i_index_base);
			end
			if (phase_q == `DFRE_PH_Q2) begin
				opnd_q <= i_mem_rdata;
			end
		end
	end

	// ****************************************
	// Process stage
	// ****************************************
	always @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			res_q <= `DFRE_RST_BYTE;
			flags_q <= `DFRE_RST_FLAGS;
		end else begin
			if (phase_q == `DFRE_PH_Q3) begin
				res_q <= res_d;
				flags_q <= flags_d;
			end
		end
	end

	// ****************************************
	// Write stage
	// ****************************************
	always @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mem_wr <= 1'b0;
			o_mem_wdata <= `DFRE_RST_BYTE;
			o_acc_wr <= 1'b0;
			o_acc_wdata <= `DFRE_RST_BYTE;
			o_done <= 1'b0;
		end else begin
			o_mem_wr <= write_ph && dest_q;
			if (write_ph && dest_q) begin
				o_mem_wdata <= res_q;
			end
			o_acc_wr <= write_ph && !dest_q;
			if (write_ph && !dest_q) begin
				o_acc_wdata <= res_q;
			end
			o_done <= write_ph;
		end
	end

	// ****************************************
	// Status flag outputs
	// ****************************************
	// Flags hold between instructions so the core may read them late
	always @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_flag_wr <= 1'b0;
			o_carry_flag <= 1'b0;
			o_digit_carry_flag <= 1'b0;
			o_negative_flag <= 1'b0;
			o_overflow_flag <= 1'b0;
			o_zero_flag <= 1'b0;
		end else begin
			o_flag_wr <= write_ph;
			if (write_ph) begin
				o_carry_flag <= flags_q[0];
				o_digit_carry_flag <= flags_q[1];
				o_negative_flag <= flags_q[2];
				o_overflow_flag <= flags_q[3];
				o_zero_flag <= flags_q[4];
			end
		end
	end

endmodule // dfre_exec

// >>> sim/dfre_props.sv
module dfre_props (
	input wire i_core_clk,
	input wire i_arst_n,
	input wire i_start,
	input wire [15:0] i_instr,
	input wire [7:0] i_mem_rdata,
	input wire o_busy,
	input wire o_mem_rd,
	input wire o_mem_wr,
	input wire o_acc_wr,
	input wire o_flag_wr,
	input wire o_done,
	input wire [7:0] o_mem_wdata,
	input wire [7:0] o_acc_wdata,
	input wire o_zero_flag
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	wire tk = i_start && !o_busy && i_instr[15:10] == 6'h01;
	sequence s_take; tk; endsequence
	// Write lands four edges after the take
	sequence s_wb(d); ##4 o_done && o_flag_wr && (d ? o_mem_wr && !o_acc_wr : o_acc_wr && !o_mem_wr); endsequence
	a_read_next: assert property (s_take |=> o_mem_rd)
		else $error("no read after take");
	a_no_early: assert property (s_take |=> !o_done [*3])
		else $error("done too early");
	a_done_pulse: assert property (o_done |=> !o_done)
		else $error("done held");
	a_write_mem: assert property (s_take ##0 i_instr[9] |-> s_wb(1))
		else $error("byte not written back");
	a_write_acc: assert property (s_take ##0 !i_instr[9] |-> s_wb(0))
		else $error("accumulator not written");
	a_mem_result: assert property (o_mem_wr |-> o_mem_wdata == $past(i_mem_rdata, 3) - 8'h01)
		else $error("bad byte result");
	a_acc_result: assert property (o_acc_wr |-> o_acc_wdata == $past(i_mem_rdata, 3) - 8'h01)
		else $error("bad accumulator result");
	a_zero_flag: assert property (o_flag_wr |-> o_zero_flag == ($past(i_mem_rdata, 3) == 8'h01))
		else $error("bad zero flag");
endmodule // dfre_props
bind dfre_exec dfre_props u_dfre_props (.*);

// >>> sim/dfre_mem_model.sv
module dfre_mem_model (
	input wire logic i_clk,
	input wire logic i_wr,
	input wire logic [11:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] m [0:4095];
	// Read is combinational, so data is ready whenever it is sampled
	assign o_rdata = m[i_addr];
	always @(posedge i_clk) if (i_wr) m[i_addr] <= i_wdata;
endmodule // dfre_mem_model

// >>> sim/dfre_exec_tb.sv
module dfre_exec_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_core_clk = 0, i_arst_n = 0, i_start = 0, i_ext_set_en = 0;
	logic [15:0] i_instr = 0;
	logic [3:0] i_bank_select_value = 0;
	logic [11:0] i_index_base = 12'h100, o_mem_addr;
	logic [7:0] i_mem_rdata, o_mem_wdata, o_acc_wdata;
	logic o_busy, o_illegal, o_mem_rd, o_mem_wr, o_acc_wr, o_flag_wr, o_done;
	logic o_carry_flag, o_digit_carry_flag, o_negative_flag, o_overflow_flag, o_zero_flag;
	int fails = 0, n_compared = 0;
	dfre_exec u_dfre_exec (.*);
	dfre_mem_model u_dfre_mem_model (.i_clk(i_core_clk), .i_wr(o_mem_wr), .i_addr(o_mem_addr),
		.i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
	always #2.5 i_core_clk = ~i_core_clk;
	task chk(input logic ok);
		n_compared++;
		if (ok !== 1'b1) begin
			fails++;
			$display("MISMATCH %0t wrong value", $time);
		end
	endtask
	task end_of_test;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task op(input logic [15:0] ins, input logic e, input logic [3:0] b, input logic [11:0] ea, input logic [7:0] v);
		logic [7:0] r;
		int n;
		r = v - 8'h01;
		n = 0;
		u_dfre_mem_model.m[ea] = v;
		@(negedge i_core_clk);
		i_start = 1;
		i_instr = ins;
		i_ext_set_en = e;
		i_bank_select_value = b;
		@(negedge i_core_clk);
		i_start = 0;
		chk(o_busy === 1'b1 && o_mem_rd === 1'b1);
		while (o_done !== 1'b1 && n < 8) begin
			@(negedge i_core_clk);
			n++;
		end
		chk(n == 3);
		chk(o_mem_addr === ea);
		chk(o_mem_wr === ins[9] && (!ins[9] || o_mem_wdata === r));
		chk(o_acc_wr === !ins[9] && (ins[9] || o_acc_wdata === r));
		chk({o_carry_flag, o_digit_carry_flag, o_negative_flag, o_overflow_flag, o_zero_flag} ===
			{v != 0, v[3:0] != 0, r[7], v == 8'h80, r == 0});
		@(negedge i_core_clk);
		chk(u_dfre_mem_model.m[ea] === (ins[9] ? r : v));
		chk(o_busy === 1'b0 && o_done === 1'b0);
	endtask
	task bad_op(input logic [15:0] ins);
		@(negedge i_core_clk);
		i_start = 1;
		i_instr = ins;
		#1;
		chk(o_illegal === 1'b1);
		@(negedge i_core_clk);
		i_start = 0;
		chk(o_busy === 1'b0 && o_mem_rd === 1'b0);
	endtask
	initial begin
		repeat (4) @(negedge i_core_clk);
		i_arst_n = 1;
		op(16'h0712, 0, 4'h3, 12'h312, 8'h01);
		op(16'h0470, 0, 4'h3, 12'hf70, 8'h00);
		op(16'h065f, 1, 4'h3, 12'h15f, 8'h80);
		op(16'h0460, 1, 4'h3, 12'hf60, 8'h10);
		op(16'h0605, 0, 4'h3, 12'h005, 8'h3c);
		bad_op(16'h0812);
		end_of_test;
	end
	initial begin
		#2000;
		fails++;
		end_of_test;
	end
endmodule // dfre_exec_tb
